//--- verilog/prc_chain.sv
/*
 output precompensation chain for one channel: fir, two exponential stages,
 one bounce stage and one high-pass stage in series, apb register port,
 overflow status codes and a level interrupt.
 assumes samples and the sequencer clear pulse are synchronous to pclk.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - master enable off bypasses whole chain
// - each stage has own enable, off is transparent
// - 40 coefficients: 8 single taps, 32 paired
// - status codes normal, recent overflow, past overflow
// - status reset write clears all stage codes
// - exponential stage: relative amplitude, time constant
// - high-pass stage uses programmable time constant
// - bounce adds delayed scaled copy
// - high-pass clear selectable level or edges
// - readable latency of enabled chain
module prc_chain #(
   parameter int UPD_CYCLES_P = prc_pkg::UPD_CYCLES
) (
   input wire logic pclk, // system clock, 50 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire prc_pkg::prc_smp_t s_in, // samples from the generator
   input wire logic sequencer_clear_pulse_instruction, // clearing pulse
   output prc_pkg::prc_smp_t s_out_q, // samples to the converter
   output logic irq // interrupt, level
);
   import prc_pkg::*;

   logic [7:0] ctrl_q;
   logic [31:0] exp_q [2];
   logic [31:0] bnc_q;
   logic [15:0] hp_q;
   logic [NSTG-1:0] ists_q, ien_q;
   logic [31:0] lat_q;
   logic [15:0] coef_q [FIR_COEFS];
   logic master;
   logic [NSTG-1:0] en;
   prc_slope_t slope;
   logic setup, wr, hit;
   logic [5:0] cidx;
   logic [31:0] rd_d;

   assign master = ctrl_q[CTRL_MASTER];
   assign en = ctrl_q[CTRL_EN_LSB +: NSTG];
   assign slope = prc_slope_t'(ctrl_q[CTRL_SLOPE_LSB +: 2]);

   // apb decode; writes land at the edge where pready is sampled high
   assign setup = psel && !penable;
   assign wr = psel && penable && pready && pwrite;
   assign cidx = 6'((paddr - A_FIR) >> 2);

   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         A_CTRL, A_STCODE, A_STRST, A_LAT, A_EXP0, A_EXP1: hit = 1'b1;
         A_BNC, A_HP, A_ISTS, A_ICLR, A_IEN: hit = 1'b1;
         default: hit = (paddr >= A_FIR) && (paddr <= A_FIR_END) && (paddr[1:0] == 2'b00);
      endcase
   end

   // stage status codes
   prc_stcode_t code [NSTG];
   logic [NSTG-1:0] ovf;

   // read mux; write-only and unmapped words read zero
   always_comb begin
      rd_d = 32'h0;
      unique case (paddr)
         A_CTRL: rd_d = {24'h0, ctrl_q};
         A_STCODE: begin
            for (int k = 0; k < NSTG; k++) begin
               rd_d[2*k +: 2] = code[k];
            end
         end
         A_LAT: rd_d = lat_q;
         A_EXP0: rd_d = exp_q[0];
         A_EXP1: rd_d = exp_q[1];
         A_BNC: rd_d = bnc_q;
         A_HP: rd_d = {16'h0, hp_q};
         A_ISTS: rd_d = {27'h0, ists_q};
         A_IEN: rd_d = {27'h0, ien_q};
         default: begin
            if (hit && paddr >= A_FIR) begin
               rd_d = {16'h0, coef_q[cidx]};
            end
         end
      endcase
   end

   // zero-wait slave: pready rises in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         pslverr <= setup && !hit;
         if (setup) begin
            prdata <= pwrite ? 32'h0 : rd_d;
         end
      end
   end

   // control and stage parameter registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         exp_q[0] <= PAR_RST;
         exp_q[1] <= PAR_RST;
         bnc_q <= PAR_RST;
         hp_q <= 16'h0000;
         ien_q <= '0;
      end else if (wr) begin
         unique case (paddr)
            A_CTRL: ctrl_q <= pwdata[7:0];
            A_EXP0: exp_q[0] <= pwdata;
            A_EXP1: exp_q[1] <= pwdata;
            A_BNC: bnc_q <= {10'h0, pwdata[21:0]};
            A_HP: hp_q <= pwdata[15:0];
            A_IEN: ien_q <= pwdata[NSTG-1:0];
            default: ;
         endcase
      end
   end

   // fir coefficients; tap 0 starts at unity so the stage is benign
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coef_q[0] <= FIR_C0_RST;
         for (int k = 1; k < FIR_COEFS; k++) begin
            coef_q[k] <= 16'h0000;
         end
      end else if (wr && hit && paddr >= A_FIR) begin
         coef_q[cidx] <= pwdata[15:0];
      end
   end

   // latency report follows the master enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_q <= 32'h0;
      end else begin
         lat_q <= master ? LAT_CYC : 32'h0;
      end
   end

   // fir delay line and coefficient mapping
   logic signed [15:0] dl_q [FIR_TAPS-1];
   logic signed [15:0] xs [FIR_TAPS];
   logic signed [15:0] tap_coef [FIR_TAPS];
   logic signed [63:0] facc;
   logic [16:0] fsat;
   prc_smp_t fir_q;
   logic fir_ovf_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < FIR_TAPS - 1; i++) begin
            dl_q[i] <= 16'sh0000;
         end
      end else if (s_in.v) begin
         dl_q[0] <= s_in.d;
         for (int i = 1; i < FIR_TAPS - 1; i++) begin
            dl_q[i] <= dl_q[i-1];
         end
      end
   end

   // first taps take one coefficient each, later taps share one per pair
   always_comb begin
      facc = 64'sd0;
      xs[0] = s_in.d;
      for (int i = 1; i < FIR_TAPS; i++) begin
         xs[i] = dl_q[i-1];
      end
      for (int i = 0; i < FIR_TAPS; i++) begin
         tap_coef[i] = $signed(coef_q[i < FIR_DIRECT ? i : FIR_DIRECT + (i - FIR_DIRECT) / 2]);
         facc = facc + xs[i] * tap_coef[i];
      end
      fsat = prc_sat(facc >>> FIR_SHIFT);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fir_q <= '0;
         fir_ovf_q <= 1'b0;
      end else begin
         fir_q.v <= s_in.v;
         fir_ovf_q <= s_in.v && en[STG_FIR] && fsat[16];
         if (s_in.v) begin
            fir_q.d <= en[STG_FIR] ? fsat[15:0] : s_in.d;
         end
      end
   end

   // two exponential overshoot stages in series
   prc_smp_t e0, e1, hp_y;
   logic hp_clr;

   prc_iir #(.HPASS(1'b0)) u_exp0 (
      .pclk(pclk),
      .presetn(presetn),
      .en(en[STG_EXP0]),
      .clr(1'b0),
      .amp(exp_q[0][15:0]),
      .alpha(exp_q[0][31:16]),
      .x(fir_q),
      .y_q(e0),
      .ovf_q(ovf[STG_EXP0])
   );

   prc_iir #(.HPASS(1'b0)) u_exp1 (
      .pclk(pclk),
      .presetn(presetn),
      .en(en[STG_EXP1]),
      .clr(1'b0),
      .amp(exp_q[1][15:0]),
      .alpha(exp_q[1][31:16]),
      .x(e0),
      .y_q(e1),
      .ovf_q(ovf[STG_EXP1])
   );

   // bounce: adds a scaled copy delayed by field+1 samples
   logic signed [15:0] bdl_q [BNC_DEPTH];
   logic signed [63:0] bsum;
   logic [16:0] bsat;
   prc_smp_t bo_q;
   logic bnc_ovf_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < BNC_DEPTH; i++) begin
            bdl_q[i] <= 16'sh0000;
         end
      end else if (e1.v) begin
         bdl_q[0] <= e1.d;
         for (int i = 1; i < BNC_DEPTH; i++) begin
            bdl_q[i] <= bdl_q[i-1];
         end
      end
   end

   always_comb begin
      bsum = 64'(e1.d) + ((64'(bdl_q[bnc_q[21:16]]) * $signed(bnc_q[15:0])) >>> AMP_SHIFT);
      bsat = prc_sat(bsum);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bo_q <= '0;
         bnc_ovf_q <= 1'b0;
      end else begin
         bo_q.v <= e1.v;
         bnc_ovf_q <= e1.v && en[STG_BNC] && bsat[16];
         if (e1.v) begin
            bo_q.d <= en[STG_BNC] ? bsat[15:0] : e1.d;
         end
      end
   end

   // clearing pulse qualified by the slope selector
   logic pulse_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_prev_q <= 1'b0;
      end else begin
         pulse_prev_q <= sequencer_clear_pulse_instruction;
      end
   end

   always_comb begin
      unique case (slope)
         SL_LEVEL: hp_clr = sequencer_clear_pulse_instruction;
         SL_RISE: hp_clr = sequencer_clear_pulse_instruction && !pulse_prev_q;
         SL_FALL: hp_clr = !sequencer_clear_pulse_instruction && pulse_prev_q;
         SL_BOTH: hp_clr = sequencer_clear_pulse_instruction ^ pulse_prev_q;
      endcase
   end

   prc_iir #(.HPASS(1'b1)) u_hp (
      .pclk(pclk),
      .presetn(presetn),
      .en(en[STG_HP]),
      .clr(hp_clr),
      .amp(16'h0000),
      .alpha(hp_q),
      .x(bo_q),
      .y_q(hp_y),
      .ovf_q(ovf[STG_HP])
   );

   assign ovf[STG_FIR] = fir_ovf_q;
   assign ovf[STG_BNC] = bnc_ovf_q;

   // output register; bypass skips every stage, switching mid-stream
   // may repeat or skip up to five samples, so change it while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_out_q <= '0;
      end else begin
         s_out_q <= master ? hp_y : s_in;
      end
   end

   // status update period divider
   logic [31:0] upd_cnt_q;
   logic tick;

   assign tick = (upd_cnt_q == 32'(UPD_CYCLES_P - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upd_cnt_q <= 32'h0;
      end else begin
         upd_cnt_q <= tick ? 32'h0 : upd_cnt_q + 32'h1;
      end
   end

   // one tracker per stage, all cleared by the reset word
   for (genvar g = 0; g < NSTG; g++) begin : g_st
      prc_status u_st (
         .pclk(pclk),
         .presetn(presetn),
         .tick(tick),
         .ovf(ovf[g]),
         .clr(wr && paddr == A_STRST),
         .code_q(code[g])
      );
   end

   // sticky interrupt status; a new overflow wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ists_q <= '0;
      end else begin
         ists_q <= (ists_q & ~((wr && paddr == A_ICLR) ? pwdata[NSTG-1:0] : '0)) | ovf;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ists_q & ien_q);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_chain_on;
      s_in.v && master ##1 master [*5];
   endsequence

   a_bypass_pass: assert property (!master |=> s_out_q == $past(s_in))
      else $error("bypass did not pass the input sample");
   a_chain_order: assert property (s_chain_on |=> s_out_q.v)
      else $error("enabled chain lost a sample");
   a_fir_pairing: assert property (tap_coef[7] == $signed(coef_q[7]) && tap_coef[70] == tap_coef[71]
      && tap_coef[71] == $signed(coef_q[FIR_COEFS-1]))
      else $error("fir tap to coefficient mapping wrong");
   a_bounce_unity: assert property (en[STG_BNC] && e1.v && bnc_q[15:0] == 16'h0 |=> bo_q.d == $past(e1.d))
      else $error("zero amplitude bounce altered sample");
   a_lat_value: assert property ($rose(master) ##1 master |-> lat_q == LAT_CYC)
      else $error("latency not reported for enabled chain");
   // only an overflow on an enabled stage obliges the line to rise
   a_irq_level: assert property ((ovf & ien_q) != '0 ##1 ien_q == $past(ien_q) |=> irq)
      else $error("enabled overflow did not raise interrupt");
endmodule // prc_chain

//--- verilog/prc_pkg.sv
/*
 precompensation chain package: register map, field positions, reset values,
 timing constants, state codes, sample carrier and the saturation helper.
 assumes a 50 MHz pclk and 16-bit signed samples.
*/
package prc_pkg;
   // sample and filter geometry
   localparam int SW = 16;
   localparam int NSTG = 5;
   localparam int STG_FIR = 0;
   localparam int STG_EXP0 = 1;
   localparam int STG_EXP1 = 2;
   localparam int STG_BNC = 3;
   localparam int STG_HP = 4;
   localparam int FIR_TAPS = 72;
   localparam int FIR_COEFS = 40;
   localparam int FIR_DIRECT = 8;
   localparam int FIR_SHIFT = 14;
   localparam logic [15:0] FIR_C0_RST = 16'h4000;
   localparam int AMP_SHIFT = 15;
   localparam int BNC_DEPTH = 64;
   // byte addresses on the apb port
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STCODE = 8'h04;
   localparam logic [7:0] A_STRST = 8'h08;
   localparam logic [7:0] A_LAT = 8'h0c;
   localparam logic [7:0] A_EXP0 = 8'h10;
   localparam logic [7:0] A_EXP1 = 8'h14;
   localparam logic [7:0] A_BNC = 8'h18;
   localparam logic [7:0] A_HP = 8'h1c;
   localparam logic [7:0] A_ISTS = 8'h20;
   localparam logic [7:0] A_ICLR = 8'h24;
   localparam logic [7:0] A_IEN = 8'h28;
   localparam logic [7:0] A_FIR = 8'h40;
   localparam logic [7:0] A_FIR_END = 8'hdc;
   // control register fields and reset values
   localparam int CTRL_MASTER = 0;
   localparam int CTRL_EN_LSB = 1;
   localparam int CTRL_SLOPE_LSB = 6;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [31:0] PAR_RST = 32'h0;
   // timing: status update period and chain latency in cycles
   localparam int CLK_HZ = 50_000_000;
   localparam int UPD_PERIOD_MS = 100;
   localparam int UPD_CYCLES = CLK_HZ / 1000 * UPD_PERIOD_MS;
   localparam logic [31:0] LAT_CYC = 32'h5;

   typedef enum logic [1:0] {ST_NORMAL, ST_RECENT, ST_PAST} prc_stcode_t;
   typedef enum logic [1:0] {SL_LEVEL, SL_RISE, SL_FALL, SL_BOTH} prc_slope_t;
   typedef struct packed {
      logic v;
      logic signed [15:0] d;
   } prc_smp_t;

   // clamp to 16 bits, msb of result flags the clamp
   function automatic logic [16:0] prc_sat(input logic signed [63:0] x);
      if (x > 64'sd32767) begin
         return {1'b1, 16'h7fff};
      end else if (x < -64'sd32768) begin
         return {1'b1, 16'h8000};
      end
      return {1'b0, x[15:0]};
   endfunction
endpackage

//--- verilog/prc_status.sv
/*
 per-stage overflow status tracker with three codes.
 assumes tick is a one-cycle pulse once per update period.
*/
`timescale 1ns/1ps
module prc_status (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic tick, // update period boundary
   input wire logic ovf, // stage clamped this cycle
   input wire logic clr, // software status reset
   output prc_pkg::prc_stcode_t code_q // current status code
);
   import prc_pkg::*;
   logic seen_q;

   // overflow seen this period; set wins over clear and over the boundary
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_q <= 1'b0;
      end else if (tick || clr) begin
         seen_q <= ovf;
      end else if (ovf) begin
         seen_q <= 1'b1;
      end
   end

   // code moves only at period boundaries or on a reset write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= ST_NORMAL;
      end else if (clr) begin
         code_q <= ST_NORMAL;
      end else if (tick) begin
         if (seen_q) begin
            code_q <= ST_RECENT;
         end else if (code_q != ST_NORMAL) begin
            code_q <= ST_PAST;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_recent_code: assert property (tick && seen_q && !clr |=> code_q == ST_RECENT)
      else $error("overflow period not reported as recent");
   a_reset_clears: assert property (clr |=> code_q == ST_NORMAL)
      else $error("status reset did not clear code");
   a_past_sticky: assert property (code_q == ST_PAST && !clr |=> code_q != ST_NORMAL)
      else $error("past overflow code dropped without reset");
   a_past_move: assert property (tick && !seen_q && code_q != ST_NORMAL && !clr |=> code_q == ST_PAST)
      else $error("quiet period did not age code to past");
endmodule // prc_status

//--- verilog/prc_iir.sv
/*
 first-order recursive stage: exponential overshoot correction, or high-pass
 compensation when HPASS is set. one registered sample out per sample in.
 assumes amp is signed q1.15 and alpha an unsigned q0.16 inverse time constant.
*/
`timescale 1ns/1ps
module prc_iir #(
   parameter bit HPASS = 1'b0
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic en, // stage enable
   input wire logic clr, // clear state (high-pass only)
   input wire logic [15:0] amp, // correction amplitude
   input wire logic [15:0] alpha, // inverse time constant
   input wire prc_pkg::prc_smp_t x, // sample in
   output prc_pkg::prc_smp_t y_q, // sample out
   output logic ovf_q // clamp pulse
);
   import prc_pkg::*;
   logic signed [63:0] s_q, s_d, corr, sum;
   logic [16:0] sat;

   // exp: low-pass tracker, correction scaled by amp; hp: running integral
   always_comb begin
      if (HPASS) begin
         s_d = s_q + x.d * $signed({1'b0, alpha});
         corr = s_q >>> 16;
      end else begin
         s_d = s_q + ((((64'(x.d)) <<< 16) - s_q) * $signed({1'b0, alpha}) >>> 16);
         corr = ((64'(x.d) - (s_q >>> 16)) * $signed(amp)) >>> AMP_SHIFT;
      end
      sum = 64'(x.d) + corr;
      sat = prc_sat(sum);
   end

   // filter state; clearing only touches the high-pass integral
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (HPASS && clr) begin
         s_q <= '0;
      end else if (x.v && en) begin
         s_q <= s_d;
      end
   end

   // registered output, transparent when disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         y_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         y_q.v <= x.v;
         ovf_q <= x.v && en && sat[16];
         if (x.v) begin
            y_q.d <= en ? sat[15:0] : x.d;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_off_transp: assert property (!en && x.v |=> y_q.d == $past(x.d) && !ovf_q)
      else $error("disabled stage altered sample");
   a_exp_unity: assert property (!HPASS && en && x.v && amp == 16'h0000 |=> y_q.d == $past(x.d))
      else $error("zero amplitude overshoot stage altered sample");
   a_hp_clear: assert property (HPASS && clr |=> s_q == 64'sd0)
      else $error("high-pass state not cleared");
endmodule // prc_iir

//--- tb/prc_dac_model.sv
/*
 converter-side model: records each valid output word and its arrival time.
 assumes at most one sample per pclk, taken on the rising edge.
*/
`timescale 1ns/1ps
module prc_dac_model (
   input wire logic pclk, // system clock
   input wire prc_pkg::prc_smp_t smp // samples from the chain
);
   import prc_pkg::*;
   int got_q[$];
   time at_q[$];
   // latch every valid word, in arrival order
   always @(posedge pclk) begin
      if (smp.v) begin
         got_q.push_back(int'(smp.d));
         at_q.push_back($time);
      end
   end
endmodule // prc_dac_model

//--- tb/tb_top.sv
/*
 self-checking bench for the precompensation chain: apb master, random
 sample source, integer reference model of fir and bounce stages.
 assumes a 20-cycle status period via UPD_CYCLES_P.
*/
`timescale 1ns/1ps
module tb_top;
   import prc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, clrp, pready, pslverr, irq, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   prc_smp_t s_in, s_out_q;
   int err_count, check_count, bamp, bdel, c[0:71];
   int xh[$], fh[$], exp_q[$];
   bit mst, fir_on, bnc_on;
   time t0;
   prc_chain #(.UPD_CYCLES_P(20)) prc_chain_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .s_in(s_in), .sequencer_clear_pulse_instruction(clrp), .s_out_q(s_out_q), .irq(irq));
   prc_dac_model prc_dac_model_i (.pclk(pclk), .smp(s_out_q));
   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(logic [31:0] seen, logic [31:0] want, string m);
      check_count++;
      if (seen !== want) begin
         err_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, want);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (n >= 50) begin
         err_count++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic cfg(logic [7:0] v);
      apb(1'b1, A_CTRL, {24'h0, v});
      mst = v[CTRL_MASTER];
      fir_on = v[CTRL_EN_LSB];
      bnc_on = v[CTRL_EN_LSB + 3];
   endtask
   // coefficient k feeds one tap below 8, else a pair of taps
   task automatic setc(int k, logic [15:0] v);
      apb(1'b1, A_FIR + 8'(4 * k), {16'h0, v});
      if (k < FIR_DIRECT) c[k] = int'(signed'(v));
      else begin
         c[2 * k - 8] = int'(signed'(v));
         c[2 * k - 7] = int'(signed'(v));
      end
   endtask
   function automatic int sat(int v);
      return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
   endfunction
   // reference: fir then bounce, each transparent when off
   task automatic push_ref(int x);
      int f, y;
      xh.push_front(x);
      f = 0;
      for (int t = 0; t < 72 && t < xh.size(); t++) f += c[t] * xh[t];
      f = fir_on ? sat(f >>> FIR_SHIFT) : x;
      fh.push_front(f);
      y = (bnc_on && fh.size() > bdel) ? sat(f + ((bamp * fh[bdel]) >>> AMP_SHIFT)) : f;
      exp_q.push_back(mst ? y : x);
   endtask
   // back-to-back samples, multiples of 8 keep the scaling exact
   task automatic run(int n, int lim);
      int x;
      for (int i = 0; i < n; i++) begin
         x = (int'($urandom_range(2 * lim)) - lim) * 8;
         s_in <= '{1'b1, 16'(x)};
         clrp <= (i % 10 > 6);
         if (i == 0) t0 = $time;
         push_ref(x);
         @(posedge pclk);
      end
      s_in.v <= 1'b0;
      clrp <= 1'b0;
      repeat (12) @(posedge pclk);
   endtask
   task automatic clr;
      exp_q.delete();
      xh.delete();
      fh.delete();
      prc_dac_model_i.got_q.delete();
      prc_dac_model_i.at_q.delete();
   endtask
   task automatic flush;
      run(80, 0);
      clr();
   endtask
   task automatic cmp_all;
      chk(32'(prc_dac_model_i.got_q.size()), 32'(exp_q.size()), "sample count");
      foreach (exp_q[i]) if (i < prc_dac_model_i.got_q.size()) chk(prc_dac_model_i.got_q[i], exp_q[i], "sample");
      if (exp_q.size() > 0) chk(32'(prc_dac_model_i.at_q[0] - t0), (mst ? LAT_CYC + 2 : 2) * 20, "latency");
      clr();
   endtask
   // count outputs that a transparent stage would not give
   function automatic int ndiff();
      int n = 0;
      foreach (exp_q[i]) if (i < prc_dac_model_i.got_q.size() && prc_dac_model_i.got_q[i] != exp_q[i]) n++;
      return n;
   endfunction
   // main sequence
   initial begin
      err_count = 0;
      check_count = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      s_in = '0;
      clrp = 1'b0;
      foreach (c[i]) c[i] = 0;
      c[0] = 16384;
      bamp = 0;
      bdel = 1;
      void'($urandom(32'h40f6));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, A_CTRL, 0);
      chk(rd, 32'(CTRL_RST), "ctrl reset");
      apb(1'b0, A_FIR, 0);
      chk(rd, 32'(FIR_C0_RST), "coef0 reset");
      apb(1'b0, A_LAT, 0);
      chk(rd, 32'h0, "latency off");
      apb(1'b0, 8'h30, 0);
      chk({31'h0, er}, 32'h1, "unmapped");
      run(40, 500);
      cmp_all();
      $display("test bypass done");
      apb(1'b1, A_EXP0, 32'h2000_1000);
      apb(1'b1, A_HP, 32'h0000_1000);
      cfg(8'h01);
      apb(1'b0, A_LAT, 0);
      chk(rd, LAT_CYC, "latency on");
      run(40, 500);
      cmp_all();
      $display("test transparent done");
      cfg(8'h03);
      setc(0, 16'h1000);
      setc(3, 16'he000);
      setc(9, 16'h2000);
      setc(39, 16'h1000);
      flush();
      run(120, 300);
      cmp_all();
      apb(1'b1, A_BNC, {10'h0, 6'd4, 16'h4000});
      bamp = 16384;
      bdel = 5;
      cfg(8'h13);
      flush();
      run(60, 300);
      cmp_all();
      $display("test fir bounce done");
      // exp0 enabled ahead of a zero-amplitude bounce; output must differ from the fir-bounce reference
      apb(1'b1, A_BNC, 32'h0004_0000);
      bamp = 0;
      cfg(8'h15);
      flush();
      run(60, 300);
      chk(32'(ndiff() > 0), 32'h1, "exp acts");
      clr();
      apb(1'b1, A_EXP1, 32'h2000_1000);
      cfg(8'h09);
      flush();
      run(60, 300);
      chk(32'(ndiff() > 0), 32'h1, "exp1 acts");
      clr();
      for (int s = 0; s < 4; s++) begin
         cfg(8'(8'h21 | (s << CTRL_SLOPE_LSB)));
         apb(1'b0, A_CTRL, 0);
         chk(rd, 32'(8'h21 | (s << CTRL_SLOPE_LSB)), "slope");
         flush();
         run(60, 300);
         chk(32'(ndiff() > 0), 32'h1, "hp acts");
         clr();
      end
      $display("test exp hp done");
      cfg(8'h03);
      setc(3, 16'h0);
      setc(9, 16'h0);
      setc(39, 16'h0);
      setc(0, 16'h7fff);
      flush();
      apb(1'b1, A_ICLR, 32'h1f);
      apb(1'b1, A_STRST, 32'h1);
      run(10, 2500);
      clr();
      rd = 32'h0;
      for (int i = 0; i < 40 && rd == 32'h0; i++) apb(1'b0, A_STCODE, 0);
      chk(rd, 32'(ST_RECENT), "recent");
      repeat (50) @(posedge pclk);
      apb(1'b0, A_STCODE, 0);
      chk(rd, 32'(ST_PAST), "past");
      repeat (50) @(posedge pclk);
      apb(1'b0, A_STCODE, 0);
      chk(rd, 32'(ST_PAST), "past held");
      apb(1'b0, A_ISTS, 0);
      chk(rd, 32'h1, "irq status");
      chk({31'h0, irq}, 32'h0, "irq masked");
      apb(1'b1, A_IEN, 32'h1);
      // irq is registered one edge after the enable lands
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1, "irq raised");
      apb(1'b1, A_ICLR, 32'h1);
      apb(1'b0, A_ISTS, 0);
      chk(rd, 32'h0, "irq cleared");
      chk({31'h0, irq}, 32'h0, "irq low");
      run(10, 2500);
      clr();
      chk({31'h0, irq}, 32'h1, "irq on overflow");
      apb(1'b1, A_STRST, 32'h1);
      apb(1'b0, A_STCODE, 0);
      chk(rd, 32'h0, "status reset");
      $display("test status done");
      summarize();
   end
endmodule // tb_top
